// ===== mmie_dmem_model.sv
`timescale 1ns/1ps
// ----------------------------
// data memory beside the core
// ----------------------------
module mmie_dmem_model (
   input  wire logic        clk,
   input  wire logic [11:0] addr,
   input  wire logic        indexed,
   input  wire logic        rd,
   input  wire logic        wr,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata
);
   logic [7:0]  mem [4096];
   logic [7:0]  junk_q = 8'hA5;
   logic [11:0] idx;
   // base add for indexed mode lives elsewhere, so the offset alone picks the byte
   assign idx = indexed ? {4'h0, addr[7:0]} : addr;
   initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 37 + 11);
   // unselected bus shows changing junk, never the last byte read
   assign rdata = rd ? mem[idx] : junk_q;
   always @(posedge clk) begin
      junk_q <= junk_q + 8'h3B;
      if (wr) mem[idx] <= wdata;
   end
endmodule // mmie_dmem_model

// ===== mmie_exec.sv
`timescale 1ns/1ps
// Notes on behaviour
// - opcode 0000 0001 loads the literal into the bank select register, upper nibble kept zero.
// - opcode 0000 1110 copies the literal into the working register, flags untouched.
// - opcode 0110 111a writes the working register to the addressed data byte, flags untouched.
// - the 8-bit file field reaches any byte of one 256-byte bank.
// - bank bit 0 uses the fast-access region, bank bit 1 takes upper bits from the bank register.
// - extended set on, bank bit 0 and field at most 95 selects indexed literal offset addressing.
// - opcode 0000 1101 puts the unsigned product of work and literal in the product pair.
// - opcode 0000 001a puts the unsigned product of work and the data byte in the product pair.
// - neither multiply touches any status flag, not even for a zero product.
module mmie_exec (
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic [15:0] INSTR_WORD,
   input  wire logic        INSTR_VALID,
   input  wire logic        EXT_INSTR_EN,
   input  wire logic [7:0]  MEM_RDATA,
   output logic      [1:0]  PHASE,
   output logic      [11:0] MEM_ADDR,
   output logic             MEM_INDEXED,
   output logic             MEM_RD,
   output logic             MEM_WR,
   output logic      [7:0]  MEM_WDATA,
   output logic      [7:0]  WORK_REG,
   output logic      [7:0]  BANK_SELECT_REG,
   output logic      [7:0]  PRODUCT_HIGH,
   output logic      [7:0]  PRODUCT_LOW,
   output logic             INSTR_DONE
);

   typedef struct packed {
      logic [1:0]           phase;
      mmie_pkg::mmie_op_type op;
      logic [7:0]           lit;
      logic                 abit;
      logic [7:0]           work;
      logic [7:0]           bank;
      logic [7:0]           prod_hi;
      logic [7:0]           prod_lo;
      logic [7:0]           operand;
      logic [11:0]          addr;
      logic                 idx;
      logic                 rd;
      logic                 wr;
      logic                 done;
   } mmie_state_type;

   mmie_state_type s_q;
   mmie_state_type s_d;
   logic [15:0]    product;
   logic           taken;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function automatic mmie_pkg::mmie_op_type decode(input logic [15:0] w);
      mmie_pkg::mmie_op_type op;
      op = mmie_pkg::OP_NONE;
      if (w[15:8] == mmie_pkg::OPC_LOAD_BANK) begin
         op = mmie_pkg::OP_LOAD_BANK;
      end else if (w[15:8] == mmie_pkg::OPC_LOAD_WORK) begin
         op = mmie_pkg::OP_LOAD_WORK;
      end else if (w[15:8] == mmie_pkg::OPC_MUL_LIT) begin
         op = mmie_pkg::OP_MUL_LIT;
      end else if (w[15:9] == mmie_pkg::OPC_STORE_WORK) begin
         op = mmie_pkg::OP_STORE;
      end else if (w[15:9] == mmie_pkg::OPC_MUL_FILE) begin
         op = mmie_pkg::OP_MUL_FILE;
      end
      return op;
   endfunction

   // ----------------------------------------
   // data address generation
   // ----------------------------------------
   function automatic logic [12:0] gen_addr(input logic abit, input logic [7:0] f,
                                            input logic [7:0] bank, input logic ext);
      logic [12:0] r;
      r = {1'b0, mmie_pkg::ACCESS_LOW_BANK, f};
      if (abit) begin
         r = {1'b0, bank[3:0], f};
      end else if (ext && (f <= mmie_pkg::INDEX_LIMIT)) begin
         // offset only; the base add lives in the indexed address unit
         r = {1'b1, mmie_pkg::ACCESS_LOW_BANK, f};
      end else if (f >= mmie_pkg::ACCESS_SPLIT) begin
         r = {1'b0, mmie_pkg::ACCESS_SFR_BANK, f};
      end
      return r;
   endfunction

   // ----------------------------------------
   // phase sequencing and execution
   // ----------------------------------------
   always_comb begin
      logic        is_file;
      logic [12:0] ga;
      is_file = 1'b0;
      ga      = 13'h0000;
      s_d      = s_q;
      s_d.rd   = 1'b0;
      s_d.wr   = 1'b0;
      s_d.done = 1'b0;
      s_d.phase = s_q.phase + 2'h1;
      case (s_q.phase)
         mmie_pkg::PH_DECODE: begin
            s_d.op = mmie_pkg::OP_NONE;
            if (INSTR_VALID) begin
               s_d.op   = decode(INSTR_WORD);
               s_d.lit  = INSTR_WORD[7:0];
               s_d.abit = INSTR_WORD[8];
               is_file  = (s_d.op == mmie_pkg::OP_STORE) ||
                          (s_d.op == mmie_pkg::OP_MUL_FILE);
               ga       = gen_addr(INSTR_WORD[8], INSTR_WORD[7:0], s_q.bank, EXT_INSTR_EN);
               s_d.addr = ga[11:0];
               s_d.idx  = ga[12] && is_file;
               s_d.rd   = (s_d.op == mmie_pkg::OP_MUL_FILE);
            end
         end
         mmie_pkg::PH_READ: begin
            // literal ops take the instruction field as operand
            s_d.operand = (s_q.op == mmie_pkg::OP_MUL_FILE) ? MEM_RDATA : s_q.lit;
         end
         mmie_pkg::PH_PROCESS: begin
            s_d.wr   = (s_q.op == mmie_pkg::OP_STORE);
            s_d.done = (s_q.op != mmie_pkg::OP_NONE);
         end
         default: begin
            // write phase: no status flag path exists at all here
            case (s_q.op)
               mmie_pkg::OP_LOAD_BANK: begin
                  s_d.bank = {mmie_pkg::BANK_UPPER_RST, s_q.lit[3:0]};
               end
               mmie_pkg::OP_LOAD_WORK: begin
                  s_d.work = s_q.lit;
               end
               mmie_pkg::OP_MUL_LIT, mmie_pkg::OP_MUL_FILE: begin
                  s_d.prod_hi = product[15:8];
                  s_d.prod_lo = product[7:0];
               end
               default: begin
               end
            endcase
         end
      endcase
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         s_q <= '{phase: mmie_pkg::PH_DECODE, op: mmie_pkg::OP_NONE, lit: 8'h00, abit: 1'b0,
                  work: mmie_pkg::WORK_RST, bank: mmie_pkg::BANK_RST,
                  prod_hi: mmie_pkg::PROD_RST, prod_lo: mmie_pkg::PROD_RST,
                  operand: 8'h00, addr: 12'h000, idx: 1'b0, rd: 1'b0, wr: 1'b0,
                  done: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // product formed during the process phase, ready for the write phase
   mmie_mul8 u_mul (
      .clk       (REF_CLK),
      .rst       (RST),
      .en        (s_q.phase == mmie_pkg::PH_PROCESS),
      .a         (s_q.work),
      .b         (s_q.operand),
      .product_q (product)
   );

   assign PHASE           = s_q.phase;
   assign MEM_ADDR        = s_q.addr;
   assign MEM_INDEXED     = s_q.idx;
   assign MEM_RD          = s_q.rd;
   assign MEM_WR          = s_q.wr;
   assign MEM_WDATA       = s_q.work;
   assign WORK_REG        = s_q.work;
   assign BANK_SELECT_REG = s_q.bank;
   assign PRODUCT_HIGH    = s_q.prod_hi;
   assign PRODUCT_LOW     = s_q.prod_lo;
   assign INSTR_DONE      = s_q.done;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   // plain signal, so antecedents can join it with field tests
   assign taken = s_q.phase == mmie_pkg::PH_DECODE && INSTR_VALID &&
                  decode(INSTR_WORD) != mmie_pkg::OP_NONE;

   sequence taken_s;
      taken;
   endsequence
   sequence four_phase_s;
      s_q.phase == mmie_pkg::PH_READ ##1 s_q.phase == mmie_pkg::PH_PROCESS
      ##1 (s_q.phase == mmie_pkg::PH_WRITE && INSTR_DONE);
   endsequence

   bank_load_a: assert property (s_q.phase == mmie_pkg::PH_WRITE &&
      s_q.op == mmie_pkg::OP_LOAD_BANK |=> BANK_SELECT_REG == {4'h0, $past(s_q.lit[3:0])})
      else $error("bank load wrong");
   bank_upper_a: assert property (BANK_SELECT_REG[7:4] == 4'h0)
      else $error("bank upper bits set");
   work_load_a: assert property (s_q.phase == mmie_pkg::PH_WRITE &&
      s_q.op == mmie_pkg::OP_LOAD_WORK |=> WORK_REG == $past(s_q.lit))
      else $error("work load wrong");
   store_write_a: assert property (MEM_WR |->
      s_q.op == mmie_pkg::OP_STORE && MEM_WDATA == WORK_REG && s_q.phase == mmie_pkg::PH_WRITE)
      else $error("store write wrong");
   banked_addr_a: assert property (taken && INSTR_WORD[8] |=>
      MEM_ADDR == {$past(BANK_SELECT_REG[3:0]), $past(INSTR_WORD[7:0])} && !MEM_INDEXED)
      else $error("banked address wrong");
   indexed_mode_a: assert property (taken && !INSTR_WORD[8] && EXT_INSTR_EN &&
      INSTR_WORD[7:0] <= mmie_pkg::INDEX_LIMIT &&
      INSTR_WORD[15:8] != mmie_pkg::OPC_LOAD_BANK &&
      INSTR_WORD[15:8] != mmie_pkg::OPC_LOAD_WORK &&
      INSTR_WORD[15:8] != mmie_pkg::OPC_MUL_LIT |=> MEM_INDEXED)
      else $error("indexed mode missed");
   mul_lit_a: assert property (s_q.phase == mmie_pkg::PH_WRITE &&
      s_q.op == mmie_pkg::OP_MUL_LIT |=>
      {PRODUCT_HIGH, PRODUCT_LOW} == 16'($past(s_q.work)) * 16'($past(s_q.lit)))
      else $error("literal product wrong");
   mul_file_a: assert property (MEM_RD |-> ##3
      {PRODUCT_HIGH, PRODUCT_LOW} == 16'($past(WORK_REG, 3)) * 16'($past(MEM_RDATA, 3)))
      else $error("file product wrong");
   mul_work_kept_a: assert property (s_q.phase == mmie_pkg::PH_WRITE &&
      (s_q.op == mmie_pkg::OP_MUL_LIT || s_q.op == mmie_pkg::OP_MUL_FILE) |=> $stable(WORK_REG))
      else $error("work changed by multiply");
   one_cycle_a: assert property (taken_s |=> four_phase_s)
      else $error("phase sequence broken");

endmodule // mmie_exec

// ===== mmie_exec_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH %s exp=%h got=%h", n, e, g); end end
module mmie_exec_tb;
   // ----------------------------
   // signals and expected state
   // ----------------------------
   logic        REF_CLK = 1'b0;
   logic        RST = 1'b1;
   logic [15:0] INSTR_WORD = 16'h0000;
   logic        INSTR_VALID = 1'b0;
   logic        EXT_INSTR_EN = 1'b0;
   logic [7:0]  MEM_RDATA, MEM_WDATA, WORK_REG, BANK_SELECT_REG, PRODUCT_HIGH, PRODUCT_LOW;
   logic [1:0]  PHASE;
   logic [11:0] MEM_ADDR;
   logic        MEM_INDEXED, MEM_RD, MEM_WR, INSTR_DONE;
   logic [7:0]  mem [4096];
   logic [7:0]  work, bank;
   logic [15:0] prod;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   logic [7:0]  ops [6] = '{8'h01, 8'h0E, 8'h0D, 8'h6E, 8'h02, 8'h00};
   // bit 16 is the extended set enable
   logic [16:0] corner [12] = '{17'h00EFF, 17'h00DFF, 17'h001FA, 17'h00E00, 17'h00D77,
      17'h00E5A, 17'h16E5F, 17'h16E60, 17'h16F33, 17'h1025F, 17'h00360, 17'h0FFFF};

   mmie_exec DUT (.REF_CLK(REF_CLK), .RST(RST), .INSTR_WORD(INSTR_WORD),
      .INSTR_VALID(INSTR_VALID), .EXT_INSTR_EN(EXT_INSTR_EN), .MEM_RDATA(MEM_RDATA),
      .PHASE(PHASE), .MEM_ADDR(MEM_ADDR), .MEM_INDEXED(MEM_INDEXED), .MEM_RD(MEM_RD),
      .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA), .WORK_REG(WORK_REG),
      .BANK_SELECT_REG(BANK_SELECT_REG), .PRODUCT_HIGH(PRODUCT_HIGH),
      .PRODUCT_LOW(PRODUCT_LOW), .INSTR_DONE(INSTR_DONE));
   mmie_dmem_model MEM (.clk(REF_CLK), .addr(MEM_ADDR), .indexed(MEM_INDEXED), .rd(MEM_RD),
      .wr(MEM_WR), .wdata(MEM_WDATA), .rdata(MEM_RDATA));

   initial forever #12.5 REF_CLK = ~REF_CLK;

   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // whole run is about a thousand cycles
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         conclude();
      end
   end

   function automatic logic [11:0] addr_of(logic [15:0] w);
      if (w[8]) return {bank[3:0], w[7:0]};
      if (w[7:0] < mmie_pkg::ACCESS_SPLIT) return {mmie_pkg::ACCESS_LOW_BANK, w[7:0]};
      return {mmie_pkg::ACCESS_SFR_BANK, w[7:0]};
   endfunction

   // ----------------------------
   // one instruction cycle
   // ----------------------------
   // entered at any time; issues in the next phase 0, so calls run back to back
   task automatic run(logic [15:0] w, logic ext);
      logic        st, mf, file, ix, rec;
      logic [11:0] i;
      st = w[15:9] === mmie_pkg::OPC_STORE_WORK;
      mf = w[15:9] === mmie_pkg::OPC_MUL_FILE;
      file = st | mf;
      ix = file & ext & ~w[8] & (w[7:0] <= 8'h5F);
      rec = file | (w[15:8] inside {mmie_pkg::OPC_LOAD_BANK, mmie_pkg::OPC_LOAD_WORK,
         mmie_pkg::OPC_MUL_LIT});
      i = ix ? {4'h0, w[7:0]} : addr_of(w);
      for (int k = 0; k < 8 && PHASE !== 2'h3; k++) @(negedge REF_CLK);
      @(posedge REF_CLK);
      INSTR_WORD <= w;
      INSTR_VALID <= 1'b1;
      EXT_INSTR_EN <= ext;
      @(negedge REF_CLK);
      `CHK("phase", 2'h0, PHASE)
      `CHK("work", work, WORK_REG)
      `CHK("bank", bank, BANK_SELECT_REG)
      `CHK("prod", prod, {PRODUCT_HIGH, PRODUCT_LOW})
      @(posedge REF_CLK);
      INSTR_VALID <= 1'b0;
      @(negedge REF_CLK);
      `CHK("rd", mf, MEM_RD)
      if (file) begin
         `CHK("indexed", ix, MEM_INDEXED)
         `CHK("addr", i, ix ? {4'h0, MEM_ADDR[7:0]} : MEM_ADDR)
      end
      repeat (2) @(negedge REF_CLK);
      `CHK("done", rec, INSTR_DONE)
      `CHK("wr", st, MEM_WR)
      `CHK("wdata", work, MEM_WDATA)
      case (w[15:8])
         mmie_pkg::OPC_LOAD_BANK: bank = {4'h0, w[3:0]};
         mmie_pkg::OPC_LOAD_WORK: work = w[7:0];
         mmie_pkg::OPC_MUL_LIT: prod = 16'(work) * 16'(w[7:0]);
         default: ;
      endcase
      if (mf) prod = 16'(work) * 16'(mem[i]);
      if (st) mem[i] = work;
   endtask

   initial begin
      logic [15:0] w;
      void'($urandom(8));
      work = 8'h00;
      bank = 8'h00;
      prod = 16'h0000;
      for (int k = 0; k < 4096; k++) mem[k] = 8'(k * 37 + 11);
      repeat (20) @(posedge REF_CLK);
      RST <= 1'b0;
      foreach (corner[k]) run(corner[k][15:0], corner[k][16]);
      for (int k = 0; k < 200; k++) begin
         w = {ops[$urandom % 6], 8'($urandom)};
         if (w[15:8] inside {8'h6E, 8'h02}) w[8] = 1'($urandom);
         run(w, 1'($urandom));
      end
      run(16'h0000, 1'b0);
      // reset in mid-run must clear every register again
      @(posedge REF_CLK);
      RST <= 1'b1;
      repeat (3) @(posedge REF_CLK);
      RST <= 1'b0;
      work = 8'h00;
      bank = 8'h00;
      prod = 16'h0000;
      run(16'h0000, 1'b0);
      conclude();
   end
endmodule // mmie_exec_tb

// ===== mmie_mul8.sv
`timescale 1ns/1ps
module mmie_mul8 (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        en,
   input  wire logic [7:0]  a,
   input  wire logic [7:0]  b,
   output logic      [15:0] product_q
);
   // ----------------------------------------
   // unsigned 8x8, registered
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] prod;
   } mmie_mul_state_type;

   mmie_mul_state_type s_q;
   mmie_mul_state_type s_d;

   // registered so the wide product never sits in the write path
   always_comb begin
      s_d = s_q;
      if (en) begin
         s_d.prod = 16'(a) * 16'(b);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '{prod: {mmie_pkg::PROD_RST, mmie_pkg::PROD_RST}};
      end else begin
         s_q <= s_d;
      end
   end

   assign product_q = s_q.prod;
endmodule // mmie_mul8

// ===== mmie_pkg.sv
package mmie_pkg;

   // ----------------------------------------
   // instruction cycle phases
   // ----------------------------------------
   localparam logic [1:0] PH_DECODE  = 2'h0;
   localparam logic [1:0] PH_READ    = 2'h1;
   localparam logic [1:0] PH_PROCESS = 2'h2;
   localparam logic [1:0] PH_WRITE   = 2'h3;

   // ----------------------------------------
   // opcode patterns, upper byte of the word, upper seven bits for store and file multiply
   // ----------------------------------------
   localparam logic [7:0] OPC_LOAD_BANK   = 8'h01;
   localparam logic [7:0] OPC_LOAD_WORK   = 8'h0E;
   localparam logic [7:0] OPC_MUL_LIT     = 8'h0D;
   localparam logic [6:0] OPC_STORE_WORK  = 7'h37;
   localparam logic [6:0] OPC_MUL_FILE    = 7'h01;

   // ----------------------------------------
   // data address layout
   // ----------------------------------------
   localparam logic [7:0] ACCESS_SPLIT    = 8'h60;
   localparam logic [7:0] INDEX_LIMIT     = 8'h5F;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_SFR_BANK = 4'hF;
   localparam logic [3:0] BANK_UPPER_RST  = 4'h0;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [7:0] BANK_RST = 8'h00;
   localparam logic [7:0] PROD_RST = 8'h00;

   typedef enum logic [2:0] {
      OP_NONE      = 3'b000,
      OP_LOAD_BANK = 3'b001,
      OP_LOAD_WORK = 3'b010,
      OP_STORE     = 3'b011,
      OP_MUL_LIT   = 3'b100,
      OP_MUL_FILE  = 3'b101
   } mmie_op_type;

endpackage
